// ---- src/ccr_pkg.sv ----
package ccr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_BUCK_HIGH = 6'h17;
    localparam logic [5:0] IDX_BUCK_LOW = 6'h18;
    localparam logic [5:0] IDX_REG_HIGH = 6'h19;
    localparam logic [5:0] IDX_REG_LOW = 6'h1A;
    localparam logic [5:0] IDX_CONTROL = 6'h20;
    localparam logic [5:0] IDX_STATUS = 6'h21;

    // Control register fields
    localparam int CTL_PRESC_LSB = 0;
    localparam int CTL_PRESC_MSB = 2;
    localparam int CTL_CLEAR_BIT = 4;
    localparam int CTL_CAL_BIT = 5;
    localparam logic [2:0] PRESC_RESET = 3'h0;

    // Status register fields
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_HELD_BIT = 1;

    // Reset values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Timing: calibration interval
    localparam int CLK_PERIOD_NS = 100;
    localparam int CAL_TIME_NS = 1000000;
    localparam logic [15:0] CAL_CYCLES_DEF = 16'(CAL_TIME_NS / CLK_PERIOD_NS);

    // AHB encodings
    localparam logic HRESP_OKAY = 1'b0;

    // Calibration sequencer states
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_HELD = 2'b10
    } ccr_cal_state_t;

    // Pulses per count for a prescaler setting, minus one
    function automatic logic [7:0] presc_limit(input logic [2:0] sel);
        presc_limit = 8'((9'h001 << sel) - 9'h001);
    endfunction

endpackage

// ---- src/ccr_counter.sv ----
`timescale 1ns/100ps
module ccr_counter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic hold,
    input wire logic cal_tick,
    input wire logic pulse,
    input wire logic pulse_en,
    input wire logic [2:0] presc_sel,
    output logic [15:0] count
);
    import ccr_pkg::*;

    logic [15:0] count_ff;
    logic [7:0] div_ff;
    logic [15:0] nxt_count;
    logic [7:0] nxt_div;
    wire div_wrap = (div_ff >= presc_limit(presc_sel));
    wire take_pulse = pulse & pulse_en;

    // Next count: clear, then suspension, then calibration ticks, then prescaled pulses
    always_comb begin
        nxt_count = count_ff;
        nxt_div = div_ff;
        if (clear) begin
            nxt_count = COUNT_RESET;
            nxt_div = 8'h00;
        end else if (hold) begin
            nxt_count = count_ff;
        end else if (cal_tick) begin
            nxt_count = count_ff + 16'h0001;
        end else if (take_pulse) begin
            if (div_wrap) begin
                nxt_div = 8'h00;
                nxt_count = count_ff + 16'h0001;
            end else begin
                nxt_div = div_ff + 8'h01;
            end
        end
    end

    // Counter and prescaler state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_ff <= COUNT_RESET;
            div_ff <= 8'h00;
        end else begin
            count_ff <= nxt_count;
            div_ff <= nxt_div;
        end
    end

    assign count = count_ff;

    // Checks on counting
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_HOLD_FREEZES: assert property (hold && !clear |=> $stable(count_ff))
        else $error("counter moved while suspended");
    AST_WRAP_ZERO: assert property (
        count_ff == 16'hFFFF && !clear && !hold && (cal_tick || (take_pulse && div_wrap))
        |=> count_ff == 16'h0000)
        else $error("counter did not wrap to zero");
    AST_PRESCALE_STEP: assert property (
        !clear && !hold && !cal_tick && count_ff != nxt_count |-> take_pulse && div_wrap)
        else $error("counter advanced without full prescale");
    CVR_WRAP: cover property (count_ff == 16'hFFFF ##1 count_ff == 16'h0000);

endmodule // ccr_counter

// ---- src/ccr_readout.sv ----
`timescale 1ns/100ps
module ccr_readout #(
    parameter logic [15:0] CAL_CYCLES = ccr_pkg::CAL_CYCLES_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic buck_pulse,
    input wire logic low_power_energy_mode,
    input wire logic linear_pulse,
    input wire logic standalone_linear_regulator
);
    import ccr_pkg::*;

    // Register index decode helpers
    function automatic logic is_buck(input logic [5:0] idx);
        is_buck = (idx == IDX_BUCK_HIGH) || (idx == IDX_BUCK_LOW);
    endfunction

    function automatic logic is_reg(input logic [5:0] idx);
        is_reg = (idx == IDX_REG_HIGH) || (idx == IDX_REG_LOW);
    endfunction

    logic dp_valid_ff;
    logic dp_write_ff;
    logic [5:0] dp_idx_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic [7:0] shadow_buck_ff;
    logic [7:0] shadow_reg_ff;
    logic [2:0] presc_ff;
    logic clr_pulse_ff;
    logic cal_req_ff;
    ccr_cal_state_t cal_state_ff;
    ccr_cal_state_t nxt_cal_state;
    logic [15:0] cal_cnt_ff;
    logic [15:0] nxt_cal_cnt;
    logic [15:0] count_buck;
    logic [15:0] count_reg;
    logic [31:0] read_mux;

    // Address phase decode
    wire [5:0] ap_idx = haddr[7:2];
    wire ap_accept = hsel & htrans[1] & hready;
    wire ap_in_page = (haddr[31:8] == 24'h000000);
    wire ap_read = ap_accept & ~hwrite;
    // Only a high-byte read inside the register page refreshes a shadow
    wire ap_hi_buck = ap_read & ap_in_page & (ap_idx == IDX_BUCK_HIGH);
    wire ap_hi_reg = ap_read & ap_in_page & (ap_idx == IDX_REG_HIGH);

    // Suspension spans the address phase and the data phase of the access
    wire hold_buck = (ap_accept & ap_in_page & is_buck(ap_idx))
        | (dp_valid_ff & is_buck(dp_idx_ff));
    wire hold_reg = (ap_accept & ap_in_page & is_reg(ap_idx))
        | (dp_valid_ff & is_reg(dp_idx_ff));

    // Write data phase decode; only the control word accepts writes
    wire dp_wr = dp_valid_ff & dp_write_ff;
    wire wr_ctl = dp_wr & (dp_idx_ff == IDX_CONTROL);

    // Calibration sequencing
    wire cal_run = (cal_state_ff == CAL_RUN);
    wire cal_held = (cal_state_ff == CAL_HELD);
    wire cal_last = cal_run & (cal_cnt_ff == CAL_CYCLES - 16'h0001);
    wire cal_start = cal_req_ff & (cal_state_ff != CAL_RUN);
    wire clear_buck = clr_pulse_ff;
    // Finishing calibration wins over a clear in the same cycle
    wire clear_reg = (clr_pulse_ff & ~cal_last) | cal_start;
    wire reg_pulse_en = standalone_linear_regulator & (cal_state_ff == CAL_IDLE);

    // Read data selection
    always_comb begin
        read_mux = WORD_ZERO;
        if (ap_in_page) begin
            case (ap_idx)
                IDX_BUCK_HIGH: read_mux = {24'h000000, count_buck[15:8]};
                IDX_BUCK_LOW: read_mux = {24'h000000, shadow_buck_ff};
                IDX_REG_HIGH: read_mux = {24'h000000, count_reg[15:8]};
                IDX_REG_LOW: read_mux = {24'h000000, shadow_reg_ff};
                IDX_CONTROL: read_mux = {26'h0000000, 1'b0, 1'b0, 1'b0, presc_ff};
                IDX_STATUS: read_mux = {30'h00000000, cal_held, cal_run};
                default: read_mux = WORD_ZERO;
            endcase
        end
    end

    // Calibration next state
    always_comb begin
        nxt_cal_state = cal_state_ff;
        nxt_cal_cnt = cal_cnt_ff;
        case (cal_state_ff)
            CAL_IDLE: begin
                if (cal_start) begin
                    nxt_cal_state = CAL_RUN;
                    nxt_cal_cnt = 16'h0000;
                end
            end
            CAL_RUN: begin
                nxt_cal_cnt = cal_cnt_ff + 16'h0001;
                if (cal_last) begin
                    nxt_cal_state = CAL_HELD;
                end else if (clr_pulse_ff) begin
                    nxt_cal_state = CAL_IDLE;
                end
            end
            CAL_HELD: begin
                if (cal_start) begin
                    nxt_cal_state = CAL_RUN;
                    nxt_cal_cnt = 16'h0000;
                end else if (clr_pulse_ff) begin
                    nxt_cal_state = CAL_IDLE;
                end
            end
            default: begin
                nxt_cal_state = CAL_IDLE;
                nxt_cal_cnt = 16'h0000;
            end
        endcase
    end

    // Bus data phase tracking and read answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_idx_ff <= 6'h00;
            hrdata_ff <= WORD_ZERO;
            hreadyout_ff <= 1'b1;
            hresp_ff <= HRESP_OKAY;
        end else begin
            dp_valid_ff <= ap_accept & ap_in_page;
            dp_write_ff <= hwrite;
            dp_idx_ff <= ap_idx;
            hreadyout_ff <= 1'b1;
            hresp_ff <= HRESP_OKAY;
            if (ap_read) begin
                hrdata_ff <= read_mux;
            end
        end
    end

    // Shadow capture on high-byte reads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shadow_buck_ff <= BYTE_RESET;
            shadow_reg_ff <= BYTE_RESET;
        end else begin
            if (ap_hi_buck) begin
                shadow_buck_ff <= count_buck[7:0];
            end
            if (ap_hi_reg) begin
                shadow_reg_ff <= count_reg[7:0];
            end
        end
    end

    // Control word and its one-cycle command pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_ff <= PRESC_RESET;
            clr_pulse_ff <= 1'b0;
            cal_req_ff <= 1'b0;
        end else begin
            clr_pulse_ff <= wr_ctl & hwdata[CTL_CLEAR_BIT];
            cal_req_ff <= wr_ctl & hwdata[CTL_CAL_BIT];
            if (wr_ctl) begin
                presc_ff <= hwdata[CTL_PRESC_MSB:CTL_PRESC_LSB];
            end
        end
    end

    // Calibration state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_state_ff <= CAL_IDLE;
            cal_cnt_ff <= 16'h0000;
        end else begin
            cal_state_ff <= nxt_cal_state;
            cal_cnt_ff <= nxt_cal_cnt;
        end
    end

    // Buck output counter, counts only in the low-power mode
    ccr_counter u_buck (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(clear_buck),
        .hold(hold_buck),
        .cal_tick(1'b0),
        .pulse(buck_pulse),
        .pulse_en(low_power_energy_mode),
        .presc_sel(presc_ff),
        .count(count_buck)
    );

    // Linear output counter, also the calibration cycle counter
    ccr_counter u_reg (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(clear_reg),
        .hold(hold_reg),
        .cal_tick(cal_run),
        .pulse(linear_pulse),
        .pulse_en(reg_pulse_en),
        .presc_sel(presc_ff),
        .count(count_reg)
    );

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;

    // Checks on the register bank
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_HIGH_BUCK_DATA: assert property (
        ap_hi_buck |=> hrdata_ff == {24'h000000, $past(count_buck[15:8])})
        else $error("buck high byte read wrong");
    AST_SHADOW_CAPTURE: assert property (
        ap_hi_buck |=> shadow_buck_ff == $past(count_buck[7:0]))
        else $error("buck shadow not captured");
    AST_LOW_FROM_SHADOW: assert property (
        ap_read && ap_in_page && ap_idx == IDX_REG_LOW
        |=> hrdata_ff == {24'h000000, $past(shadow_reg_ff)})
        else $error("low byte read not from shadow");
    AST_SUSPEND_ADDR: assert property (
        ap_accept && ap_in_page && is_reg(ap_idx) && !clear_reg |=> $stable(count_reg))
        else $error("regulator counter moved while addressed");
    AST_WRITE_IGNORED: assert property (
        dp_wr && (is_buck(dp_idx_ff) || is_reg(dp_idx_ff)) && !ap_hi_buck && !ap_hi_reg
        |=> $stable(shadow_buck_ff) && $stable(shadow_reg_ff))
        else $error("write to counter register changed state");
    AST_CAL_LENGTH: assert property (
        $rose(cal_held) |-> $past(cal_run) && $past(cal_cnt_ff) == CAL_CYCLES - 16'h0001)
        else $error("calibration interval wrong length");
    AST_CAL_RESULT_KEPT: assert property (
        cal_held && !clr_pulse_ff && !cal_start |=> $stable(count_reg))
        else $error("calibration result changed before clear");
    AST_ALWAYS_READY: assert property (
        hreadyout_ff && hresp_ff == HRESP_OKAY)
        else $error("slave stalled or errored");

    // Read answers of the regulator high byte, its shadow capture, the buck low byte and the low-lane placement
    AST_HIGH_REG_DATA: assert property (
        ap_hi_reg |=> hrdata_ff == {24'h000000, $past(count_reg[15:8])})
        else $error("regulator high byte read wrong");
    AST_REG_SHADOW_CAPTURE: assert property (
        ap_hi_reg |=> shadow_reg_ff == $past(count_reg[7:0]))
        else $error("regulator shadow not captured");
    AST_LOW_BUCK_SHADOW: assert property (
        ap_read && ap_in_page && ap_idx == IDX_BUCK_LOW
        |=> hrdata_ff == {24'h000000, $past(shadow_buck_ff)})
        else $error("buck low byte read not from shadow");
    AST_BYTE_IN_LOW_LANE: assert property (
        ap_read && ap_in_page && (is_buck(ap_idx) || is_reg(ap_idx))
        |=> hrdata_ff[31:8] == 24'h000000)
        else $error("counter byte not in low lane");

    // Suspension over both phases and its end
    AST_SUSPEND_BUCK: assert property (
        ap_accept && ap_in_page && is_buck(ap_idx) && !clear_buck |=> $stable(count_buck))
        else $error("buck counter moved while addressed");
    AST_SUSPEND_DATA: assert property (
        dp_valid_ff && is_reg(dp_idx_ff) && !clear_reg |=> $stable(count_reg))
        else $error("regulator counter moved in data phase");
    AST_SUSPEND_ENDS: assert property (
        (dp_valid_ff && !ap_accept) ##1 !ap_accept |-> !hold_buck && !hold_reg)
        else $error("suspension outlived the access");

    // Calibration start and clear outcomes
    AST_CAL_START_CLEARS: assert property (
        cal_start |=> cal_run && count_reg == COUNT_RESET)
        else $error("calibration did not restart from zero");
    AST_CLEAR_ENDS_RESULT: assert property (
        clr_pulse_ff && !cal_last |=> !cal_held && count_reg == COUNT_RESET)
        else $error("clear left calibration result");

    CVR_COHERENT_PAIR: cover property (ap_hi_buck ##[1:8] (ap_read && ap_idx == IDX_BUCK_LOW));
    CVR_CAL_DONE: cover property (cal_run ##1 cal_held);
    CVR_CLEAR_AFTER_CAL: cover property (cal_held && clr_pulse_ff);

endmodule // ccr_readout

// ---- test/ccr_host.sv ----
`timescale 1ns/100ps
module ccr_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus points at an unmapped word so no counter sits frozen
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_00FC;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // One single word transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= 32'h0000_00FC;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule // ccr_host

// ---- test/coulomb_count_readout_tb.sv ----
`timescale 1ns/100ps
module coulomb_count_readout_tb;
    typedef struct {logic [2:0] presc; int n; logic b_en; logic l_en;} ccr_row_t;
    localparam logic [15:0] CAL_N = 16'h0014;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic buck_pulse, linear_pulse, low_power_energy_mode, standalone_linear_regulator;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] eb, el;
    logic [31:0] sts;
    int n_fail = 0;
    int cmp_count = 0;
    ccr_row_t rows [4] = '{'{3'h0, 5, 1'b1, 1'b1}, '{3'h1, 8, 1'b1, 1'b0},
                           '{3'h3, 24, 1'b0, 1'b1}, '{3'h7, 256, 1'b1, 1'b1}};

    ccr_readout #(.CAL_CYCLES(CAL_N)) i_ccr_readout (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .buck_pulse(buck_pulse), .low_power_energy_mode(low_power_energy_mode),
        .linear_pulse(linear_pulse), .standalone_linear_regulator(standalone_linear_regulator));
    ccr_host i_ccr_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // 10 MHz clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_ccr_host.xfer(1'b0, a, 32'h0000_0000, q);
        chk(name, e, q);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_ccr_host.xfer(1'b1, a, d, q);
        repeat (2) @(posedge hclk);
    endtask

    // Isolated one-cycle pulses with a gap between them
    task automatic send_pulses(input int n, input logic b, input logic l);
        repeat (n) begin
            @(posedge hclk);
            buck_pulse <= b;
            linear_pulse <= l;
            @(posedge hclk);
            buck_pulse <= 1'b0;
            linear_pulse <= 1'b0;
        end
    endtask

    // Hang guard, well above the expected run length
    initial begin
        repeat (90000) @(posedge hclk);
        n_fail++;
        print_verdict();
    end

    // Main sequence
    initial begin
        hresetn = 1'b0;
        buck_pulse = 1'b0;
        linear_pulse = 1'b0;
        low_power_energy_mode = 1'b0;
        standalone_linear_regulator = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // Table: clear, set prescaler, count, read both counters
        foreach (rows[i]) begin
            wr(32'h80, 32'h10 | {29'h0, rows[i].presc});
            low_power_energy_mode <= rows[i].b_en;
            standalone_linear_regulator <= rows[i].l_en;
            send_pulses(rows[i].n, 1'b1, 1'b1);
            eb = rows[i].b_en ? 16'(rows[i].n >> rows[i].presc) : 16'h0000;
            el = rows[i].l_en ? 16'(rows[i].n >> rows[i].presc) : 16'h0000;
            rd_chk("control", 32'h80, {29'h0, rows[i].presc});
            rd_chk("buck_high", 32'h5C, {24'h0, eb[15:8]});
            rd_chk("buck_low", 32'h60, {24'h0, eb[7:0]});
            rd_chk("reg_high", 32'h64, {24'h0, el[15:8]});
            rd_chk("reg_low", 32'h68, {24'h0, el[7:0]});
        end
        $display("test table done");
        // Shadow coherence, lost pulses while addressed, ignored writes
        wr(32'h80, 32'h10);
        low_power_energy_mode <= 1'b1;
        send_pulses(300, 1'b1, 1'b0);
        rd_chk("buck_high", 32'h5C, 32'h01);
        send_pulses(10, 1'b1, 1'b0);
        rd_chk("buck_low", 32'h60, 32'h2C);
        fork
            rd_chk("buck_high_frozen", 32'h5C, 32'h01);
            begin
                @(posedge hclk);
                buck_pulse <= 1'b1;
                repeat (2) @(posedge hclk);
                buck_pulse <= 1'b0;
            end
        join
        send_pulses(3, 1'b1, 1'b0);
        for (int a = 32'h5C; a <= 32'h68; a += 4) wr(32'(a), 32'h0000_00FF);
        rd_chk("buck_low_shadow", 32'h60, 32'h36);
        rd_chk("buck_high", 32'h5C, 32'h01);
        rd_chk("buck_low_lost", 32'h60, 32'h39);
        rd_chk("unmapped", 32'h0000_0100, 32'h0);
        $display("test shadow done");
        // Calibration: save regulator count first, then run
        send_pulses(2, 1'b0, 1'b1);
        rd_chk("reg_save_high", 32'h64, 32'h00);
        rd_chk("reg_save_low", 32'h68, 32'h02);
        wr(32'h80, 32'h20);
        rd_chk("status_run", 32'h84, 32'h1);
        for (int k = 0; k < 50; k++) begin
            i_ccr_host.xfer(1'b0, 32'h84, 32'h0, sts);
            if (sts[0] === 1'b0) break;
        end
        standalone_linear_regulator <= 1'b1;
        send_pulses(5, 1'b0, 1'b1);
        rd_chk("status_held", 32'h84, 32'h2);
        rd_chk("cal_high", 32'h64, {24'h0, CAL_N[15:8]});
        rd_chk("cal_low", 32'h68, {24'h0, CAL_N[7:0]});
        wr(32'h80, 32'h10);
        rd_chk("cleared_high", 32'h64, 32'h0);
        rd_chk("cleared_low", 32'h68, 32'h0);
        $display("test calibration done");
        // Mid-run reset returns every counter register to zero
        send_pulses(4, 1'b1, 1'b1);
        // A full turn of back-to-back pulses brings the buck count round to 4
        @(posedge hclk);
        buck_pulse <= 1'b1;
        repeat (65536) @(posedge hclk);
        buck_pulse <= 1'b0;
        rd_chk("buck_high", 32'h5C, 32'h0);
        rd_chk("buck_wrap_low", 32'h60, 32'h04);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("rst_buck_high", 32'h5C, 32'h0);
        rd_chk("rst_buck_low", 32'h60, 32'h0);
        rd_chk("rst_reg_high", 32'h64, 32'h0);
        rd_chk("rst_reg_low", 32'h68, 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
        $display("test reset done");
        print_verdict();
    end
endmodule // coulomb_count_readout_tb
